// ---- t1cl_pkg.sv ----
`default_nettype none
package t1cl_pkg;
  // ==========================================================
  // Register map, word index, byte address is index times four
  localparam int unsigned ADDR_W         = 10;
  localparam logic [7:0]  IDX_SIG_CTRL   = 8'h14;
  localparam logic [7:0]  IDX_CODE_LOOP  = 8'h15;
  localparam logic [7:0]  IDX_RESERVED   = 8'h16;
  localparam logic [7:0]  IDX_SLIP_DELAY = 8'h17;
  localparam logic [7:0]  IDX_STATUS     = 8'h20;
  // ==========================================================
  // Field positions
  localparam int unsigned SIG_JAPAN_YELLOW_SELECT   = 0;
  localparam int unsigned SIG_SM_LSB = 1;
  localparam int unsigned SIG_RBE    = 5;
  localparam int unsigned CL_PAYLOAD_LOOPBACK    = 0;
  localparam int unsigned CL_BACKPLANE_LOOPBACK    = 1;
  localparam int unsigned CL_REMOTE_LOOPBACK    = 2;
  localparam int unsigned CL_DIGITAL_LOOPBACK    = 3;
  localparam int unsigned CL_FBS     = 4;
  localparam int unsigned CL_TXB8    = 5;
  localparam int unsigned CL_METALLIC_LOOPBACK    = 6;
  localparam int unsigned CL_RXB8    = 7;
  localparam int unsigned STAT_YEL   = 0;
  localparam int unsigned STAT_SLIP  = 1;
  // ==========================================================
  // Reset values
  localparam logic [7:0]  SIG_CTRL_RST   = 8'h00;
  localparam logic [7:0]  CODE_LOOP_RST  = 8'h00;
  localparam logic [7:0]  SLIP_VALUE_RST = 8'h0F;
  // ==========================================================
  // Bus answers
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_DECERR = 2'h3;
  // ==========================================================
  // Line coding and framing
  localparam logic [7:0]  FRAME_LAST = 8'hC0;
  localparam logic [7:0]  B8ZS_PULSE = 8'h1B;
  localparam logic [7:0]  B8ZS_VIOL  = 8'h12;
  localparam logic [15:0] YEL_STD    = 16'hFF00;
  localparam logic [15:0] YEL_JAPAN  = 16'hFFFF;
  // ==========================================================
  // Types
  typedef struct packed {
    logic pos;
    logic neg;
  } t1cl_line_t;

  typedef enum logic [1:0] {
    SLIP_IDLE  = 2'h0,
    SLIP_ARMED = 2'h1,
    SLIP_COUNT = 2'h3
  } t1cl_slip_t;

  typedef struct packed {
    t1cl_line_t        rxSync1;
    t1cl_line_t        rxSync2;
    t1cl_line_t        txEnc;
    t1cl_line_t        txLine;
    logic [7:0]        sigCtrl;
    logic [7:0]        codeLoop;
    logic [7:0]        slipValue;
    logic [7:0]        slipCnt;
    logic [7:0]        frameCnt;
    t1cl_slip_t        slipState;
    logic              frameStart;
    logic [7:0]        txShift;
    logic [7:0]        subPulse;
    logic [7:0]        subViol;
    logic              lastPol;
    logic [7:0]        rxWinPos;
    logic [7:0]        rxWinNeg;
    logic [7:0]        rxData;
    logic [7:0]        rxOctShift;
    logic [7:0]        rxOctet;
    logic [7:0]        bpOut;
    logic              rxValid;
    logic [3:0]        sigOut;
    logic [15:0]       yelPat;
    logic [15:0]       fdlShift;
    logic              yelDet;
    logic              awHeld;
    logic              wHeld;
    logic [ADDR_W-1:0] awAddr;
    logic [7:0]        wData;
    logic              wStrb0;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [7:0]        rdata;
    logic [1:0]        rresp;
  } t1cl_state_t;
endpackage : t1cl_pkg
`default_nettype wire

// ---- t1cl_top.sv ----
`timescale 1ns/10ps
`default_nettype none
// How it works
// - D4 nibble fills vacant bits from message field
// - D4 nibble order: A, B, upper, lower
// - ESF nibble carries ABCD, message field ignored
// - Japan select uses sixteen ones yellow
// - Receive B8ZS decoding when enabled
// - Metallic loopback: receive pins onto transmit pins
// - Transmit B8ZS replaces all-zero octets
// - Forced stuffing sets bit 1 of zero octets
// - Digital loopback feeds transmit stream to receive
// - Remote loopback sends received line data back
// - Backplane loopback: input copied to output
// - Payload loopback: received octets to transmit
// - Payload loop overwrites LSB on signaling frames
// - Clear-channel slot suppresses robbed bit insertion
// - Delay write gives one-time slip adjustment
// - Delay counted from channel one write
// - Delay shifts internal frame boundary only
// - Delay always below one frame
// - Robbed bits into LSB on frames flagged by txSigFrame
module t1cl_top (
  // Clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  input  wire logic                        clkEn,
  // AXI4-Lite slave
  input  wire logic [t1cl_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                        awvalid,
  output logic                             awready,
  input  wire logic [31:0]                 wdata,
  input  wire logic [3:0]                  wstrb,
  input  wire logic                        wvalid,
  output logic                             wready,
  output logic [1:0]                       bresp,
  output logic                             bvalid,
  input  wire logic                        bready,
  input  wire logic [t1cl_pkg::ADDR_W-1:0] araddr,
  input  wire logic                        arvalid,
  output logic                             arready,
  output logic [31:0]                      rdata,
  output logic [1:0]                       rresp,
  output logic                             rvalid,
  input  wire logic                        rready,
  // Line pins
  input  wire logic                        receiveLinePos,
  input  wire logic                        receiveLineNeg,
  output logic                             transmitLinePos,
  output logic                             transmitLineNeg,
  // Framer timing
  input  wire logic                        lineTick,
  input  wire logic                        txOctetStrobe,
  input  wire logic                        rxOctetStrobe,
  input  wire logic                        bpWriteCh1,
  output logic                             txFrameStart,
  // Backplane data
  input  wire logic [7:0]                  backplaneDataIn,
  output logic [7:0]                       backplaneDataOut,
  output logic                             rxOctetValid,
  // Signaling
  input  wire logic                        esfMode,
  input  wire logic [3:0]                  rxSigBits,
  input  wire logic                        txSigBit,
  input  wire logic                        txSigFrame,
  input  wire logic                        txClearChannel,
  output logic [3:0]                       signalingSerialOut,
  // Yellow alarm
  input  wire logic                        fdlTick,
  input  wire logic                        fdlRxBit,
  output logic [15:0]                      yellowTxPattern,
  output logic                             yellowDetected
);
  import t1cl_pkg::*;

  // ==========================================================
  // Decoding
  function automatic logic t1cl_mapped(input logic [ADDR_W-1:0] a);
    logic [7:0] idx;
    idx = a[ADDR_W-1:2];
    return (a[1:0] == 2'h0) &&
           (idx == IDX_SIG_CTRL || idx == IDX_CODE_LOOP ||
            idx == IDX_RESERVED || idx == IDX_SLIP_DELAY ||
            idx == IDX_STATUS);
  endfunction : t1cl_mapped

  function automatic logic t1cl_b8zs_hit(input logic [7:0] p,
                                         input logic [7:0] q);
    return ((p | q) == B8ZS_PULSE) && (p[4] != p[3]) &&
           (p[3] == p[1]) && (p[1] != p[0]);
  endfunction : t1cl_b8zs_hit

  // ==========================================================
  // State
  t1cl_state_t s;
  t1cl_state_t n;
  t1cl_line_t  rxSrc;
  logic        wrFire;
  logic [7:0]  wrIdx;
  logic        slipWrite;
  logic [1:0]  smField;
  logic        japan_yellow_select;
  logic        rbe;
  logic [15:0] yelSel;
  logic [3:0]  expNibble;
  logic [7:0]  rdSel;
  logic [7:0]  rdIdx;

  assign smField = s.sigCtrl[SIG_SM_LSB +: 2];
  assign japan_yellow_select    = s.sigCtrl[SIG_JAPAN_YELLOW_SELECT];
  assign rbe     = s.sigCtrl[SIG_RBE];
  assign yelSel  = japan_yellow_select ? YEL_JAPAN : YEL_STD;
  // Digital loopback swaps the receive source ahead of decoding
  assign rxSrc   = s.codeLoop[CL_DIGITAL_LOOPBACK] ? s.txEnc : s.rxSync2;
  assign expNibble = esfMode ? rxSigBits : {rxSigBits[3:2], smField};

  assign wrFire    = s.awHeld && s.wHeld && !s.bvalid;
  assign wrIdx     = s.awAddr[ADDR_W-1:2];
  assign slipWrite = wrFire && t1cl_mapped(s.awAddr) && s.wStrb0 &&
                     (wrIdx == IDX_SLIP_DELAY);
  assign rdIdx     = araddr[ADDR_W-1:2];

  always_comb begin
    rdSel = 8'h00;
    case (rdIdx)
      IDX_SIG_CTRL:  rdSel = s.sigCtrl;
      IDX_CODE_LOOP: rdSel = s.codeLoop;
      IDX_STATUS: begin
        rdSel[STAT_YEL]  = s.yelDet;
        rdSel[STAT_SLIP] = (s.slipState != SLIP_IDLE);
      end
      default:       rdSel = 8'h00;
    endcase
  end

  // ==========================================================
  // Bus handshakes, frozen with the clock enable
  assign awready = clkEn && !s.awHeld && !s.bvalid;
  assign wready  = clkEn && !s.wHeld && !s.bvalid;
  assign bvalid  = clkEn && s.bvalid;
  assign bresp   = s.bresp;
  assign arready = clkEn && !s.rvalid;
  assign rvalid  = clkEn && s.rvalid;
  assign rdata   = {24'h000000, s.rdata};
  assign rresp   = s.rresp;

  // ==========================================================
  // Next state
  always_comb begin
    logic [7:0] winP;
    logic [7:0] winN;
    logic [7:0] dat;
    logic [7:0] oct;
    logic [15:0] fs;
    logic       rxBit;
    logic       pulse;
    logic       pol;
    winP  = 8'h00;
    winN  = 8'h00;
    dat   = 8'h00;
    oct   = 8'h00;
    fs    = 16'h0000;
    rxBit = 1'b0;
    pulse = 1'b0;
    pol   = 1'b0;
    n = s;
    n.rxValid    = 1'b0;
    n.frameStart = 1'b0;
    n.rxSync1    = {receiveLinePos, receiveLineNeg};
    n.rxSync2    = s.rxSync1;
    n.yelPat     = yelSel;

    // Register bus
    if (awvalid && awready) begin
      n.awHeld = 1'b1;
      n.awAddr = awaddr;
    end
    if (wvalid && wready) begin
      n.wHeld  = 1'b1;
      n.wData  = wdata[7:0];
      n.wStrb0 = wstrb[0];
    end
    if (wrFire) begin
      n.awHeld = 1'b0;
      n.wHeld  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = t1cl_mapped(s.awAddr) ? RESP_OKAY : RESP_DECERR;
      if (t1cl_mapped(s.awAddr) && s.wStrb0) begin
        case (wrIdx)
          IDX_SIG_CTRL:  n.sigCtrl  = s.wData;
          IDX_CODE_LOOP: n.codeLoop = s.wData;
          default:       n.sigCtrl  = n.sigCtrl;
        endcase
      end
    end
    if (s.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    if (arvalid && arready) begin
      n.rvalid = 1'b1;
      n.rdata  = rdSel;
      n.rresp  = t1cl_mapped(araddr) ? RESP_OKAY : RESP_DECERR;
    end
    if (s.rvalid && rready) begin
      n.rvalid = 1'b0;
    end

    // Line bit time
    if (lineTick) begin
      winP  = {s.rxWinPos[6:0], rxSrc.pos};
      winN  = {s.rxWinNeg[6:0], rxSrc.neg};
      dat   = {s.rxData[6:0], rxSrc.pos | rxSrc.neg};
      rxBit = s.rxData[7];
      // Zero the whole window so a code is never decoded twice
      if (s.codeLoop[CL_RXB8] && t1cl_b8zs_hit(winP, winN)) begin
        dat  = 8'h00;
        winP = 8'h00;
        winN = 8'h00;
      end
      n.rxWinPos   = winP;
      n.rxWinNeg   = winN;
      n.rxData     = dat;
      n.rxOctShift = {s.rxOctShift[6:0], rxBit};

      if (s.codeLoop[CL_REMOTE_LOOPBACK]) begin
        pulse = rxBit;
      end else begin
        pulse = s.txShift[7] | s.subPulse[7];
      end
      // Violations repeat the last polarity, others alternate
      pol = (s.subViol[7] && !s.codeLoop[CL_REMOTE_LOOPBACK]) ?
            s.lastPol : !s.lastPol;
      if (pulse) begin
        n.lastPol = pol;
      end
      n.txEnc    = pulse ? {pol, !pol} : 2'h0;
      n.txShift  = {s.txShift[6:0], 1'b0};
      n.subPulse = {s.subPulse[6:0], 1'b0};
      n.subViol  = {s.subViol[6:0], 1'b0};

      if (s.frameCnt == FRAME_LAST) begin
        n.frameCnt   = 8'h00;
        n.frameStart = 1'b1;
      end else begin
        n.frameCnt = s.frameCnt + 8'h01;
      end
    end

    // Octet into the transmit encoder, wins over a shift
    if (txOctetStrobe) begin
      oct = s.codeLoop[CL_PAYLOAD_LOOPBACK] ? s.rxOctet : backplaneDataIn;
      // Clear channel keeps the looped signaling intact
      if (rbe && txSigFrame && !txClearChannel) begin
        oct[0] = txSigBit;
      end
      if (s.codeLoop[CL_FBS] && oct == 8'h00) begin
        oct[1] = 1'b1;
      end
      n.txShift  = oct;
      n.subPulse = 8'h00;
      n.subViol  = 8'h00;
      if (s.codeLoop[CL_TXB8] && oct == 8'h00) begin
        n.subPulse = B8ZS_PULSE;
        n.subViol  = B8ZS_VIOL;
      end
    end

    // Metallic path bypasses the encoder entirely
    n.txLine = s.codeLoop[CL_METALLIC_LOOPBACK] ? s.rxSync2 : n.txEnc;

    // Received octet to the backplane and signaling nibble
    if (rxOctetStrobe) begin
      n.rxOctet = n.rxOctShift;
      n.bpOut   = s.codeLoop[CL_BACKPLANE_LOOPBACK] ? backplaneDataIn : n.rxOctShift;
      n.rxValid = 1'b1;
      n.sigOut  = expNibble;
    end

    // Facility link yellow detection
    if (fdlTick) begin
      fs         = {s.fdlShift[14:0], fdlRxBit};
      n.fdlShift = fs;
      n.yelDet   = (fs == yelSel);
    end

    // One-time slip delay; backplane timing is never touched
    if (slipWrite) begin
      n.slipValue = (s.wData > FRAME_LAST) ? FRAME_LAST : s.wData;
      n.slipState = SLIP_ARMED;
    end else begin
      case (s.slipState)
        SLIP_IDLE:  n.slipState = SLIP_IDLE;
        SLIP_ARMED: begin
          if (bpWriteCh1) begin
            n.slipCnt   = s.slipValue;
            n.slipState = SLIP_COUNT;
          end
        end
        SLIP_COUNT: begin
          if (lineTick) begin
            if (s.slipCnt == 8'h00) begin
              n.frameCnt   = 8'h00;
              n.frameStart = 1'b1;
              n.slipState  = SLIP_IDLE;
            end else begin
              n.slipCnt = s.slipCnt - 8'h01;
            end
          end
        end
        default:    n.slipState = SLIP_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s           <= '0;
      s.sigCtrl   <= SIG_CTRL_RST;
      s.codeLoop  <= CODE_LOOP_RST;
      s.slipValue <= SLIP_VALUE_RST;
      s.slipState <= SLIP_IDLE;
      s.yelPat    <= YEL_STD;
    end else if (clkEn) begin
      s <= n;
    end
  end

  // ==========================================================
  // Outputs
  assign transmitLinePos    = s.txLine.pos;
  assign transmitLineNeg    = s.txLine.neg;
  assign txFrameStart       = s.frameStart;
  assign backplaneDataOut   = s.bpOut;
  assign rxOctetValid       = s.rxValid;
  assign signalingSerialOut = s.sigOut;
  assign yellowTxPattern    = s.yelPat;
  assign yellowDetected     = s.yelDet;

  // ==========================================================
  // Checks
  chk_nibble_fill: assert property (@(posedge ref_clk) disable iff (rst)
    clkEn && rxOctetStrobe && !esfMode |=>
      signalingSerialOut == {$past(rxSigBits[3:2]), $past(smField)})
    else $error("D4 nibble wrong");

  chk_nibble_esf: assert property (@(posedge ref_clk) disable iff (rst)
    clkEn && rxOctetStrobe && esfMode |=>
      signalingSerialOut == $past(rxSigBits))
    else $error("ESF nibble wrong");

  chk_yellow_select: assert property (@(posedge ref_clk) disable iff (rst)
    clkEn ##1 $stable(japan_yellow_select) |->
      yellowTxPattern == (japan_yellow_select ? YEL_JAPAN : YEL_STD))
    else $error("Yellow pattern wrong");

  chk_metallic_path: assert property (@(posedge ref_clk) disable iff (rst)
    clkEn && s.codeLoop[CL_METALLIC_LOOPBACK] |=>
      {transmitLinePos, transmitLineNeg} == $past(s.rxSync2))
    else $error("Metallic loop broken");

  chk_zero_subst: assert property (@(posedge ref_clk) disable iff (rst)
    clkEn && txOctetStrobe && s.codeLoop[CL_TXB8] && !s.codeLoop[CL_FBS]
      && !s.codeLoop[CL_PAYLOAD_LOOPBACK] && backplaneDataIn == 8'h00 && !rbe |=>
      s.subPulse == B8ZS_PULSE && s.subViol == B8ZS_VIOL)
    else $error("B8ZS not loaded");

  chk_forced_stuff: assert property (@(posedge ref_clk) disable iff (rst)
    clkEn && txOctetStrobe && s.codeLoop[CL_FBS] |=>
      s.txShift != 8'h00 && s.subPulse == 8'h00)
    else $error("Zero octet not stuffed");

  chk_backplane_loop: assert property (@(posedge ref_clk) disable iff (rst)
    clkEn && rxOctetStrobe && s.codeLoop[CL_BACKPLANE_LOOPBACK] |=>
      backplaneDataOut == $past(backplaneDataIn) && rxOctetValid)
    else $error("Backplane loop broken");

  chk_robbed_bit: assert property (@(posedge ref_clk) disable iff (rst)
    clkEn && txOctetStrobe && rbe && txSigFrame |=>
      s.txShift[0] == ($past(txClearChannel) ? ($past(s.codeLoop[CL_PAYLOAD_LOOPBACK]) ?
        $past(s.rxOctet[0]) : $past(backplaneDataIn[0])) : $past(txSigBit)))
    else $error("Robbed bit wrong");

  chk_slip_arm: assert property (@(posedge ref_clk) disable iff (rst)
    clkEn && slipWrite |=> s.slipState == SLIP_ARMED &&
      s.slipValue <= FRAME_LAST)
    else $error("Delay write not armed");

  chk_slip_bound: assert property (@(posedge ref_clk) disable iff (rst)
    s.slipCnt <= FRAME_LAST && s.frameCnt <= FRAME_LAST)
    else $error("Slip count too long");

  chk_bus_hold: assert property (@(posedge ref_clk) disable iff (rst)
    s.bvalid && !(bready && clkEn) |=> s.bvalid)
    else $error("Write answer dropped");
endmodule : t1cl_top
`default_nettype wire

// ---- t1cl_line_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module t1cl_line_model (
  // Clock and bit timing
  input  wire logic       ref_clk,
  input  wire logic       lineTick,
  // Octet repeated on the line, MSB first
  input  wire logic [7:0] lineByte,
  // Receive pair towards the block
  output logic            linePos,
  output logic            lineNeg
);
  logic [2:0] bitIdx = 3'h0;
  logic       pol    = 1'b0;
  logic       posR   = 1'b0;
  logic       negR   = 1'b0;
  logic       mark;

  assign linePos = posR;
  assign lineNeg = negR;
  assign mark    = lineByte[3'h7 - bitIdx];

  // ==========================================
  // Plain AMI: marks alternate, spaces leave both low
  always @(posedge ref_clk) begin
    if (lineTick) begin
      posR    <= mark & ~pol;
      negR    <= mark & pol;
      pol     <= pol ^ mark;
      bitIdx  <= bitIdx + 3'h1;
    end
  end
endmodule : t1cl_line_model
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
  import t1cl_pkg::*;
  // ==========================================
  // Bench signals
  logic        ref_clk = 1'b0;
  logic        rst     = 1'b1;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, ch1 = 1'b0;
  logic [9:0]  awaddr  = 10'h000, araddr = 10'h000;
  logic [31:0] wdata   = 32'h0, rdata;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        rxP, rxN, txP, txN, txFs, rxOv, yelDet, tick;
  logic        esf = 1'b0, sigBit = 1'b0, sigFr = 1'b0, en = 1'b1;
  logic        clr = 1'b0, fdlBit = 1'b0;
  logic [7:0]  bpIn = 8'h00, bpOut, lineByte = 8'h00, m, p;
  logic [15:0] yelPat;
  logic [3:0]  sigOut;
  logic [4:0]  cyc = 5'h00;
  logic [9:0]  v;
  int          t;
  int          error_cnt = 0;
  int          checked = 0;

  // ==========================================
  // Clock; a bit every 4 cycles, an octet every 32
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 5'h01;
  assign tick = cyc[1:0] == 2'h2;

  t1cl_top t1cl_top_inst (
    .ref_clk(ref_clk), .rst(rst), .clkEn(en),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'h1), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .receiveLinePos(rxP), .receiveLineNeg(rxN),
    .transmitLinePos(txP), .transmitLineNeg(txN),
    .lineTick(tick), .txOctetStrobe(cyc == 5'h00),
    .rxOctetStrobe(cyc == 5'h1F), .bpWriteCh1(ch1), .txFrameStart(txFs),
    .backplaneDataIn(bpIn), .backplaneDataOut(bpOut), .rxOctetValid(rxOv),
    .esfMode(esf), .rxSigBits(4'hB), .txSigBit(sigBit),
    .txSigFrame(sigFr), .txClearChannel(clr), .signalingSerialOut(sigOut),
    .fdlTick(cyc == 5'h03), .fdlRxBit(fdlBit), .yellowTxPattern(yelPat),
    .yellowDetected(yelDet)
  );

  t1cl_line_model t1cl_line_model_inst (
    .ref_clk(ref_clk), .lineTick(tick), .lineByte(lineByte),
    .linePos(rxP), .lineNeg(rxN)
  );

  // ==========================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  task automatic bound(input logic hit);
    if (hit) begin
      check(32'h0, 32'h1);
      test_done();
    end
  endtask : bound

  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                    input logic [1:0] expR);
    int n;
    @(posedge ref_clk);
    awaddr  <= {idx, 2'h0};
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
    end
    bound(n == 64);
    bready <= 1'b0;
    check(bresp, expR);
  endtask : wr

  task automatic rd(input logic [7:0] idx, output logic [9:0] rv);
    int n;
    @(posedge ref_clk);
    araddr  <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
    end
    bound(n == 64);
    rready <= 1'b0;
    rv = {rresp, rdata[7:0]};
    check(rdata[31:8], 24'h0);
  endtask : rd

  task automatic octs(input int n);
    repeat (n * 32) @(posedge ref_clk);
  endtask : octs

  // Pulse mask and positive marks of one sent octet, MSB first
  task automatic cap();
    int n;
    for (n = 0; n < 40; n++) begin
      @(posedge ref_clk);
      if (cyc == 5'h05) break;
    end
    for (n = 0; n < 8; n++) begin
      m = {m[6:0], txP | txN};
      p = {p[6:0], txP};
      repeat (4) @(posedge ref_clk);
    end
  endtask : cap

  // Ticks until the next transmit frame start
  task automatic to_fs();
    int n;
    t = 0;
    for (n = 0; n < 1000; n++) begin
      @(posedge ref_clk);
      if (txFs) break;
      if (tick) t++;
    end
    bound(n == 1000);
  endtask : to_fs

  // ==========================================
  // Scenarios
  task automatic t_regs();
    rd(IDX_SIG_CTRL, v);
    check(v, {RESP_OKAY, SIG_CTRL_RST});
    rd(IDX_CODE_LOOP, v);
    check(v, {RESP_OKAY, CODE_LOOP_RST});
    wr(IDX_RESERVED, 8'hA5, RESP_OKAY);
    rd(IDX_RESERVED, v);
    check(v, {RESP_OKAY, 8'h00});
    wr(IDX_SLIP_DELAY, 8'h0F, RESP_OKAY);
    rd(IDX_SLIP_DELAY, v);
    check(v, {RESP_OKAY, 8'h00});
    wr(IDX_SIG_CTRL, 8'hC6, RESP_OKAY);
    rd(IDX_SIG_CTRL, v);
    check(v, {RESP_OKAY, 8'hC6});
    rd(8'h30, v);
    check(v[9:8], RESP_DECERR);
    wr(8'h31, 8'h01, RESP_DECERR);
  endtask : t_regs

  task automatic t_sig();
    wr(IDX_SIG_CTRL, 8'h04, RESP_OKAY);
    octs(2);
    check(sigOut, 4'hA);
    // Clock enable low: nibble frozen, bus not ready
    en  <= 1'b0;
    esf <= 1'b1;
    octs(2);
    check(sigOut, 4'hA);
    check({awready, wready, arready}, 3'h0);
    en <= 1'b1;
    octs(2);
    check(sigOut, 4'hB);
  endtask : t_sig

  task automatic t_yel();
    fdlBit <= 1'b1;
    wr(IDX_SIG_CTRL, 8'h00, RESP_OKAY);
    octs(20);
    check({yelPat, yelDet}, {YEL_STD, 1'b0});
    wr(IDX_SIG_CTRL, 8'h01, RESP_OKAY);
    octs(20);
    check({yelPat, yelDet}, {16'hFFFF, 1'b1});
    rd(IDX_STATUS, v);
    check({v[9:8], v[0]}, {RESP_OKAY, 1'b1});
    fdlBit <= 1'b0;
  endtask : t_yel

  task automatic t_tx();
    wr(IDX_SIG_CTRL, 8'h00, RESP_OKAY);
    wr(IDX_CODE_LOOP, 8'h00, RESP_OKAY);
    octs(1);
    cap();
    check(m, 8'h00);
    wr(IDX_CODE_LOOP, 8'h10, RESP_OKAY);
    octs(1);
    cap();
    check(m, 8'h02);
    wr(IDX_CODE_LOOP, 8'h20, RESP_OKAY);
    octs(1);
    cap();
    check(m, 8'h1B);
    check(p, p[4] ? 8'h11 : 8'h0A);
    wr(IDX_CODE_LOOP, 8'h00, RESP_OKAY);
    wr(IDX_SIG_CTRL, 8'h20, RESP_OKAY);
    bpIn  <= 8'hFF;
    sigFr <= 1'b1;
    octs(1);
    cap();
    check(m, 8'hFE);
    wr(IDX_SIG_CTRL, 8'h00, RESP_OKAY);
    sigFr <= 1'b0;
  endtask : t_tx

  task automatic t_loop();
    bpIn <= 8'h5A;
    wr(IDX_CODE_LOOP, 8'h02, RESP_OKAY);
    octs(2);
    check(bpOut, 8'h5A);
    // Octet valid pulse stands one cycle after the strobe
    for (t = 0; t < 32 && cyc != 5'h00; t++) @(posedge ref_clk);
    check(rxOv, 1'b1);
    @(posedge ref_clk);
    check(rxOv, 1'b0);
    bpIn <= 8'hFF;
    wr(IDX_CODE_LOOP, 8'h08, RESP_OKAY);
    octs(4);
    check(bpOut, 8'hFF);
    bpIn <= 8'h00;
    wr(IDX_CODE_LOOP, 8'hA8, RESP_OKAY);
    octs(4);
    check(bpOut, 8'h00);
    wr(IDX_CODE_LOOP, 8'h28, RESP_OKAY);
    octs(4);
    check(bpOut != 8'h00, 1'b1);
    lineByte <= 8'hFF;
    wr(IDX_CODE_LOOP, 8'h04, RESP_OKAY);
    octs(4);
    cap();
    check(m, 8'hFF);
    wr(IDX_CODE_LOOP, 8'h40, RESP_OKAY);
    octs(2);
    cap();
    check({m, p == 8'hAA || p == 8'h55}, {8'hFF, 1'b1});
    wr(IDX_CODE_LOOP, 8'h00, RESP_OKAY);
    octs(2);
    cap();
    check(m, 8'h00);
    wr(IDX_CODE_LOOP, 8'h01, RESP_OKAY);
    octs(4);
    cap();
    check(m, 8'hFF);
    wr(IDX_SIG_CTRL, 8'h20, RESP_OKAY);
    sigFr <= 1'b1;
    octs(1);
    cap();
    check(m, 8'hFE);
    clr <= 1'b1;
    octs(1);
    cap();
    check(m, 8'hFF);
  endtask : t_loop

  task automatic t_slip();
    to_fs();
    wr(IDX_SLIP_DELAY, 8'h0F, RESP_OKAY);
    repeat (2) @(posedge ref_clk);
    for (t = 0; t < 4 && cyc[1:0] != 2'h0; t++) @(posedge ref_clk);
    ch1 <= 1'b1;
    @(posedge ref_clk);
    ch1 <= 1'b0;
    to_fs();
    check(t, 32'd16);
    ch1 <= 1'b1;
    @(posedge ref_clk);
    ch1 <= 1'b0;
    // No second adjustment: a full 193-bit frame follows
    to_fs();
    check(t, 32'd193);
  endtask : t_slip

  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_regs();
    t_sig();
    t_yel();
    t_tx();
    t_loop();
    t_slip();
    test_done();
  end
endmodule : tb
`default_nettype wire
